//--- logic/blm_backlight_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// [RULE_01] Group bit one turns on independent sinks
// [RULE_02] Group bit ignored while any per-sink set
// [RULE_03] Group bit zero turns independent sinks off
// [RULE_04] Host keeps per-sink bits zero for group
// [RULE_05] Auto mode follows comparator level, ignores manual
// [RULE_06] Host enables an ambient level for auto
// [RULE_07] Manual mode uses manual level field only
// [RULE_08] Backlight drives only when enabled and running
// [RULE_09] Fade completion sets flag bit five
// [RULE_10] Overload sets flag bit four
// [RULE_11] Thermal shutdown sets flag bit three
// [RULE_12] Pump overvoltage sets flag bit two
// [RULE_13] Second light comparator sets flag bit one
// [RULE_14] First light comparator sets flag bit zero
// [RULE_15] Flags clear only on written one
// [RULE_16] Interrupt when flag and mask both set
// [RULE_17] Masked flag still sets, no interrupt
// [RULE_18] Mode bit five selects run or standby
// [RULE_19] Flags sticky; bits seven and six zero
module blm_backlight_ctrl
    import blm_pkg::*;
#(
    parameter int NUM_SINKS = BLM_NUM_SINKS,
    parameter int LEVEL_W = BLM_LEVEL_W
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [BLM_NUM_FLAGS-1:0] event_raw,
    input wire logic [LEVEL_W-1:0] cmp_level_raw,
    output logic [NUM_SINKS-1:0] sink_on,
    output logic backlight_drive,
    output logic [LEVEL_W-1:0] level_out,
    output logic run_active,
    output logic irq
);
    // Reset release chain
    logic rst_meta; // Feeds rst_sync only
    logic rst_sync; // Released reset for the whole block

    // Software-visible state
    logic [7:0] mode; // Run, group, auto and backlight bits
    logic [7:0] mask; // Interrupt enables
    logic [LEVEL_W-1:0] manual_level_select; // Manual backlight level
    logic [NUM_SINKS-1:0] sink_cfg; // Sinks designated independent
    logic [NUM_SINKS-1:0] per_sink_on; // Direct per-sink enables
    logic indep_sink_group_on; // Effective group state

    // Comparator level synchroniser
    logic [LEVEL_W-1:0] cmp_meta; // Read only by cmp_sync
    logic [LEVEL_W-1:0] cmp_sync;

    // Decoded mode bits and other internal nets
    logic run_not_sleep;
    logic auto_level_follow;
    logic backlight_on;
    logic wr_mode;
    logic any_per_sink;
    logic [BLM_NUM_FLAGS-1:0] pending;
    logic [NUM_SINKS-1:0] next_sink_on;
    logic [7:0] next_rdata;

    blm_flag_if #(.N(BLM_NUM_FLAGS)) fl ();

    // Reset is asserted at once but released on a clock edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Event capture lives in its own bank
    blm_flag_bank #(.N(BLM_NUM_FLAGS)) u_flags (
        .sys_clk(sys_clk),
        .rst_n(rst_sync),
        .event_raw(event_raw),
        .fl(fl.bank)
    );

    // Field decode
    assign run_not_sleep = mode[BLM_RUN_BIT];
    assign auto_level_follow = mode[BLM_AUTO_BIT];
    assign backlight_on = mode[BLM_BL_BIT];
    assign wr_mode = reg_wr && (reg_addr == BLM_MODE_ADDR);
    assign any_per_sink = |per_sink_on;

    // Status writes go straight to the bank as a clear mask
    assign fl.clear_stb = reg_wr && (reg_addr == BLM_STAT_ADDR); // RULE_15
    assign fl.clear_bits = reg_wdata[BLM_NUM_FLAGS-1:0];

    // Register writes; unmapped offsets are dropped
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            mode <= BLM_MODE_RESET;
            mask <= BLM_MASK_RESET;
            manual_level_select <= BLM_LEVEL_RESET[LEVEL_W-1:0];
            sink_cfg <= BLM_SINKCFG_RESET[NUM_SINKS-1:0];
            per_sink_on <= BLM_PERSINK_RESET[NUM_SINKS-1:0];
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                BLM_MODE_ADDR: mode <= reg_wdata & BLM_MODE_WMASK; // RULE_18
                BLM_MASK_ADDR: mask <= {2'b00, reg_wdata[BLM_NUM_FLAGS-1:0]};
                BLM_LEVEL_ADDR: manual_level_select <= reg_wdata[LEVEL_W-1:0];
                BLM_SINKCFG_ADDR: sink_cfg <= reg_wdata[NUM_SINKS-1:0];
                BLM_PERSINK_ADDR: per_sink_on <= reg_wdata[NUM_SINKS-1:0];
                default: mode <= mode; // Status and unmapped: no stored value
            endcase
        end
    end

    // Group state changes only on a mode write while per-sink bits are all zero;
    // a write made while any per-sink bit is set leaves it as it was
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            indep_sink_group_on <= 1'b0;
        end
        else if (wr_mode && !any_per_sink) // RULE_02 RULE_04
        begin
            indep_sink_group_on <= reg_wdata[BLM_GROUP_BIT]; // RULE_01 RULE_03
        end
    end

    // Sink selection; per-sink bits take precedence over the group
    always_comb
    begin
        next_sink_on = '0;
        if (!run_not_sleep)
        begin
            next_sink_on = '0; // RULE_18
        end
        else if (any_per_sink)
        begin
            next_sink_on = per_sink_on; // RULE_02
        end
        else if (indep_sink_group_on)
        begin
            next_sink_on = sink_cfg; // RULE_01
        end
        else
        begin
            next_sink_on = '0; // RULE_03
        end
    end

    // Registered sink drive
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            sink_on <= '0;
        end
        else
        begin
            sink_on <= next_sink_on;
        end
    end

    // Backlight enable gated by standby
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            backlight_drive <= 1'b0;
            run_active <= 1'b0;
        end
        else
        begin
            backlight_drive <= backlight_on && run_not_sleep; // RULE_08
            run_active <= run_not_sleep; // RULE_18
        end
    end

    // Comparator level comes from analog pins, so settle it first
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            cmp_meta <= '0;
            cmp_sync <= '0;
        end
        else
        begin
            cmp_meta <= cmp_level_raw;
            cmp_sync <= cmp_meta;
        end
    end

    // Level source; enabling ambient zones is software's job
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            level_out <= '0;
        end
        else if (auto_level_follow)
        begin
            level_out <= cmp_sync; // RULE_05 RULE_06
        end
        else
        begin
            level_out <= manual_level_select; // RULE_07
        end
    end

    // Only unmasked flags reach the host pin
    assign pending = fl.flags & mask[BLM_NUM_FLAGS-1:0];

    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |pending; // RULE_16 RULE_17
        end
    end

    // Read mux; reserved and unmapped bits read as zero
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            BLM_MODE_ADDR: next_rdata = mode;
            BLM_STAT_ADDR: next_rdata = {2'b00, fl.flags}; // RULE_19
            BLM_MASK_ADDR: next_rdata = mask;
            BLM_LEVEL_ADDR: next_rdata = {{(8-LEVEL_W){1'b0}}, manual_level_select};
            BLM_SINKCFG_ADDR: next_rdata = {{(8-NUM_SINKS){1'b0}}, sink_cfg};
            BLM_PERSINK_ADDR: next_rdata = {{(8-NUM_SINKS){1'b0}}, per_sink_on};
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data is held until the next read; reading has no side effect
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            reg_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync);

    a_group_drives_cfg: assert property ( // RULE_01
        (indep_sink_group_on && !any_per_sink && run_not_sleep)
        |=> (sink_on == $past(sink_cfg)))
        else $error("Group on did not drive the independent sinks");
    a_group_write_ignored: assert property ( // RULE_02
        (wr_mode && any_per_sink) |=> (indep_sink_group_on == $past(indep_sink_group_on)))
        else $error("Group bit changed while per-sink bits set");
    a_group_off_dark: assert property ( // RULE_03
        (!indep_sink_group_on && !any_per_sink) |=> (sink_on == '0))
        else $error("Sinks on with group off");
    a_auto_level: assert property (auto_level_follow |=> (level_out == $past(cmp_sync))) // RULE_05
        else $error("Auto level not taken from comparators");
    a_manual_level: assert property ( // RULE_07
        !auto_level_follow |=> (level_out == $past(manual_level_select)))
        else $error("Manual level not used");
    a_backlight_gate: assert property ( // RULE_08
        !(backlight_on && run_not_sleep) |=> !backlight_drive)
        else $error("Backlight driven while disabled or in standby");
    a_irq_gating: assert property ( // RULE_16
        ##1 (irq == $past(|(fl.flags & mask[BLM_NUM_FLAGS-1:0]))))
        else $error("Interrupt does not match enabled flags");
    a_masked_quiet: assert property ( // RULE_17
        ((fl.flags & mask[BLM_NUM_FLAGS-1:0]) == '0) |=> !irq)
        else $error("Interrupt raised by a masked flag");
    a_standby_off: assert property ( // RULE_18
        !run_not_sleep |=> (sink_on == '0 && !backlight_drive))
        else $error("Outputs active in standby");
    a_reserved_zero: assert property ( // RULE_19
        (reg_rd && reg_addr == BLM_STAT_ADDR) |=> (reg_rdata[7:6] == 2'b00))
        else $error("Reserved status bits not zero");

    c_group_on: cover property (wr_mode && reg_wdata[BLM_GROUP_BIT] && !any_per_sink ##2 |sink_on);
    c_auto_mode: cover property (auto_level_follow && backlight_drive);
    c_irq_raise: cover property (!irq ##1 irq);
    c_clear_flag: cover property (fl.clear_stb && |fl.flags);
endmodule // blm_backlight_ctrl
`default_nettype wire

//--- logic/blm_flag_bank.sv
`timescale 1ns/1ns
`default_nettype none
module blm_flag_bank
    import blm_pkg::*;
#(
    parameter int N = 6
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [N-1:0] event_raw,
    blm_flag_if.bank fl
);
    logic [N-1:0] sync1; // First stage, read only by sync2
    logic [N-1:0] sync2; // Settled event level
    logic [N-1:0] prev; // Delayed copy for edge find
    logic [N-1:0] rise; // One-cycle event pulses
    logic [N-1:0] next_flags;

    // Two-flop synchroniser plus edge history
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
        end
        else
        begin
            sync1 <= event_raw;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // A condition that stays asserted sets its flag only once per onset
    assign rise = sync2 & ~prev;

    // Clear first, then set, so a same-cycle event survives the clear
    always_comb
    begin
        next_flags = fl.flags;
        if (fl.clear_stb)
        begin
            next_flags = next_flags & ~fl.clear_bits; // RULE_15
        end
        next_flags = next_flags | rise; // RULE_09 RULE_10 RULE_11 RULE_12 RULE_13 RULE_14
    end

    // Sticky flags hold until cleared by the host
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fl.flags <= BLM_FLAG_RESET[N-1:0];
        end
        else
        begin
            fl.flags <= next_flags; // RULE_19
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_event_sets_flag: assert property (|rise |=> (($past(rise) & ~fl.flags) == '0)) // RULE_09
        else $error("Event did not set its flag");
    a_flag_stays_set: assert property ( // RULE_19
        !fl.clear_stb |=> ((fl.flags & $past(fl.flags)) == $past(fl.flags)))
        else $error("Flag dropped without a clear");
    a_clear_by_one: assert property ( // RULE_15
        fl.clear_stb
        |=> ((fl.flags & $past(fl.flags & ~fl.clear_bits)) == $past(fl.flags & ~fl.clear_bits)))
        else $error("Zero write cleared a flag");
    a_set_beats_clear: assert property ( // RULE_10
        (fl.clear_stb && |(rise & fl.clear_bits)) |=> (($past(rise) & ~fl.flags) == '0))
        else $error("Clear swallowed a same-cycle event");
    c_flag_set: cover property (|rise ##1 |fl.flags);
endmodule // blm_flag_bank
`default_nettype wire

//--- logic/blm_flag_if.sv
`timescale 1ns/1ns
`default_nettype none
// Flag bank to register logic link
interface blm_flag_if #(parameter int N = 6);
    logic [N-1:0] flags; // Sticky flag state
    logic [N-1:0] clear_bits; // Write-one-to-clear data
    logic clear_stb; // Status write strobe
    modport bank (output flags, input clear_bits, input clear_stb);
    modport ctrl (input flags, output clear_bits, output clear_stb);
endinterface
`default_nettype wire

//--- logic/blm_pkg.sv
`default_nettype none
package blm_pkg;
    // Register offsets on the serial register port
    localparam logic [7:0] BLM_MODE_ADDR = 8'h01;
    localparam logic [7:0] BLM_STAT_ADDR = 8'h02;
    localparam logic [7:0] BLM_MASK_ADDR = 8'h03;
    localparam logic [7:0] BLM_LEVEL_ADDR = 8'h04;
    localparam logic [7:0] BLM_SINKCFG_ADDR = 8'h05;
    localparam logic [7:0] BLM_PERSINK_ADDR = 8'h1b;
    // Mode control field positions
    localparam int BLM_RUN_BIT = 5;
    localparam int BLM_GROUP_BIT = 2;
    localparam int BLM_AUTO_BIT = 1;
    localparam int BLM_BL_BIT = 0;
    // Flag positions in status and mask
    localparam int BLM_FADE_BIT = 5;
    localparam int BLM_OVERLOAD_BIT = 4;
    localparam int BLM_OVERHEAT_BIT = 3;
    localparam int BLM_OVERVOLT_BIT = 2;
    localparam int BLM_CMP_B_BIT = 1;
    localparam int BLM_CMP_A_BIT = 0;
    // Sizes
    localparam int BLM_NUM_FLAGS = 6;
    localparam int BLM_NUM_SINKS = 7;
    localparam int BLM_LEVEL_W = 3;
    // Reset values
    localparam logic [7:0] BLM_MODE_RESET = 8'h00;
    localparam logic [7:0] BLM_MASK_RESET = 8'h00;
    localparam logic [7:0] BLM_LEVEL_RESET = 8'h00;
    localparam logic [7:0] BLM_SINKCFG_RESET = 8'h00;
    localparam logic [7:0] BLM_PERSINK_RESET = 8'h00;
    localparam logic [7:0] BLM_FLAG_RESET = 8'h00;
    // Writable bits of the mode register
    localparam logic [7:0] BLM_MODE_WMASK = 8'h27;
endpackage
`default_nettype wire

//--- tb/blm_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host side of the register port, one byte per strobe
module blm_host_model
(
    input wire logic sys_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // Idle bus at time zero
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // Single byte write; data inverted once released so stale values never pass
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask

    // Single byte read; data taken after the strobe edge has landed
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
        #1;
        data = reg_rdata;
    endtask
endmodule // blm_host_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import blm_pkg::*;
;
    logic sys_clk = 1'b0; // 10 MHz
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [5:0] event_raw = 6'h00; // Fade, fault and comparator events
    logic [2:0] cmp_level_raw = 3'h0; // Comparator level code
    logic [6:0] sink_on;
    logic backlight_drive, run_active, irq;
    logic [2:0] level_out;
    int err_total = 0;
    int checked = 0;
    logic [31:0] seed = 32'h6d8c; // Fixed seed, repeatable run
    logic [7:0] d, m, sc, ps;
    logic [2:0] lv, cv;

    // Clock
    always #50 sys_clk = ~sys_clk;

    blm_host_model host_u (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    blm_backlight_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .event_raw(event_raw), .cmp_level_raw(cmp_level_raw), .sink_on(sink_on),
        .backlight_drive(backlight_drive), .level_out(level_out), .run_active(run_active),
        .irq(irq));

    // Xorshift source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected interrupt level from flags and mask
    function automatic logic [7:0] exp_irq(input logic [7:0] f, input logic [7:0] k);
        return {7'h00, |(f & k & 8'h3f)};
    endfunction

    // Single comparison point
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Let registered outputs follow a write
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog, far beyond the expected few hundred cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        finish_test();
    end

    // Main sequence
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(3);
        // Reset values, unmapped offset reads zero
        check({sink_on, backlight_drive}, 8'h00, "outputs at reset");
        check({3'h0, level_out, run_active, irq}, 8'h00, "status at reset");
        host_u.rd(BLM_MODE_ADDR, d);
        check(d, BLM_MODE_RESET, "mode reset");
        host_u.rd(BLM_STAT_ADDR, d);
        check(d, BLM_FLAG_RESET, "flags reset");
        host_u.rd(BLM_MASK_ADDR, d);
        check(d, BLM_MASK_RESET, "mask reset");
        host_u.wr(8'h7e, 8'hff);
        host_u.rd(8'h7e, d);
        check(d, 8'h00, "unmapped");
        // Mask and mode readback, reserved bits dropped
        m = xs();
        host_u.wr(BLM_MASK_ADDR, m);
        host_u.rd(BLM_MASK_ADDR, d);
        check(d, m & 8'h3f, "mask readback");
        host_u.wr(BLM_MODE_ADDR, 8'hff);
        host_u.rd(BLM_MODE_ADDR, d);
        check(d, BLM_MODE_WMASK, "mode readback");
        // Each event source in turn: set, write-zero, sticky, clear
        for (int i = 0; i < 6; i++)
        begin
            m = xs() & 8'h3f;
            host_u.wr(BLM_MASK_ADDR, m);
            @(posedge sys_clk);
            event_raw <= 6'h01 << i;
            settle(6);
            host_u.rd(BLM_STAT_ADDR, d);
            check(d, 8'h01 << i, "flag set");
            check({7'h00, irq}, exp_irq(8'h01 << i, m), "irq level");
            host_u.wr(BLM_STAT_ADDR, ~(8'h01 << i));
            @(posedge sys_clk);
            event_raw <= 6'h00;
            settle(5);
            host_u.rd(BLM_STAT_ADDR, d);
            check(d, 8'h01 << i, "flag sticky");
            host_u.wr(BLM_STAT_ADDR, 8'h01 << i);
            host_u.rd(BLM_STAT_ADDR, d);
            check(d, 8'h00, "flag cleared");
            settle(2);
            check({7'h00, irq}, 8'h00, "irq dropped");
        end
        // All events together, reserved bits stay zero
        host_u.wr(BLM_MASK_ADDR, 8'h00);
        @(posedge sys_clk);
        event_raw <= 6'h3f;
        settle(6);
        host_u.rd(BLM_STAT_ADDR, d);
        check(d, 8'h3f, "all flags");
        check({7'h00, irq}, 8'h00, "masked irq");
        host_u.wr(BLM_STAT_ADDR, 8'hff);
        @(posedge sys_clk);
        event_raw <= 6'h00;
        host_u.rd(BLM_STAT_ADDR, d);
        check(d, 8'h00, "clear all, no re-set");
        // Onset timed so its edge pulse meets the clear strobe; the set must win
        @(posedge sys_clk);
        event_raw <= 6'h10;
        @(posedge sys_clk);
        host_u.wr(BLM_STAT_ADDR, 8'h10);
        host_u.rd(BLM_STAT_ADDR, d);
        check(d, 8'h10, "set beats clear");
        @(posedge sys_clk);
        event_raw <= 6'h00;
        host_u.wr(BLM_STAT_ADDR, 8'h10);
        host_u.rd(BLM_STAT_ADDR, d);
        check(d, 8'h00, "late clear");
        // Group sink control, per-sink override, standby
        for (int k = 0; k < 3; k++)
        begin
            sc = xs() & 8'h7f;
            host_u.wr(BLM_SINKCFG_ADDR, sc);
            host_u.wr(BLM_PERSINK_ADDR, 8'h00);
            host_u.wr(BLM_MODE_ADDR, 8'h25);
            settle(2);
            check({1'b0, sink_on}, sc, "group on");
            check({6'h00, backlight_drive, run_active}, 8'h03, "running lit");
            host_u.wr(BLM_MODE_ADDR, 8'h20);
            settle(2);
            check({1'b0, sink_on}, 8'h00, "group off");
            check({7'h00, backlight_drive}, 8'h00, "backlight off");
            ps = (xs() & 8'h7f) | 8'h01;
            host_u.wr(BLM_PERSINK_ADDR, ps);
            host_u.wr(BLM_MODE_ADDR, 8'h25);
            settle(2);
            check({1'b0, sink_on}, ps, "per-sink wins");
            host_u.wr(BLM_PERSINK_ADDR, 8'h00);
            settle(2);
            check({1'b0, sink_on}, 8'h00, "group write ignored");
            host_u.wr(BLM_MODE_ADDR, 8'h25);
            host_u.wr(BLM_MODE_ADDR, 8'h05);
            settle(2);
            check({sink_on, backlight_drive}, 8'h00, "standby dark");
            check({7'h00, run_active}, 8'h00, "standby flag");
        end
        // Manual versus automatic level choice
        for (int k = 0; k < 4; k++)
        begin
            lv = xs();
            cv = ~lv;
            host_u.wr(BLM_MODE_ADDR, 8'h21);
            host_u.wr(BLM_LEVEL_ADDR, {5'h00, lv});
            @(posedge sys_clk);
            cmp_level_raw <= cv;
            settle(5);
            check({5'h00, level_out}, {5'h00, lv}, "manual level");
            // Ambient zone enables sit outside this block; auto mode taken as armed
            host_u.wr(BLM_MODE_ADDR, 8'h23);
            settle(5);
            check({5'h00, level_out}, {5'h00, cv}, "auto level");
        end
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
